// ---- src/async_timer_sync_and_prescaler.sv ----
`timescale 1ns/100ps
module async_timer_sync_and_prescaler (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Crystal oscillator pin and port takeover
  input wire logic xtal_in_pin_in,
  output logic xtal_port_release_out,
  output logic osc_enable_out,
  // Processor side
  input wire logic global_irq_enable_in,
  input wire logic compare_vector_ack_in,
  input wire logic overflow_vector_ack_in,
  input wire logic light_sleep_in,
  input wire logic deep_sleep_in,
  output logic compare_irq_out,
  output logic overflow_irq_out,
  output logic wake_out,
  output logic cpu_stall_out,
  // Compare output pin
  output logic compare_pin_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Oscillator pin synchroniser and edge history
  logic xtal_meta_q;
  logic xtal_sync_q;
  logic xtal_prev_q;
  // Clock source and sleep history
  logic async_sel_q;
  logic deep_prev_q;
  // Prescaler and its pending reset
  logic [9:0] pre_q;
  logic prs_pend_q;
  // Holding slots and their transfer state
  logic [7:0] temp_q [3];
  logic [2:0] pend_q;
  logic [2:0] edge_seen_q;
  // Timer-domain registers
  logic [7:0] cnt_q;
  logic [7:0] cmp_q;
  logic [7:0] ctl_q;
  logic [7:0] rd_cnt_q;
  logic block_q;
  logic oc_q;
  // Flag pipes, flags and mask
  logic [2:0] cm_pipe_q;
  logic [2:0] ov_pipe_q;
  logic cf_q;
  logic of_q;
  logic [7:0] mask_q;
  // Wake-up and stall
  logic wake_pend_q;
  logic armed_q;
  logic wake_q;
  logic [2:0] stall_q;
  logic [31:0] prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in;
  wire sel_cnt = paddr_in == rtc_timer_pkg::OFS_COUNTER;
  wire sel_cmp = paddr_in == rtc_timer_pkg::OFS_COMPARE;
  wire sel_ctl = paddr_in == rtc_timer_pkg::OFS_CONTROL;
  wire sel_sts = paddr_in == rtc_timer_pkg::OFS_ASYNC_STATUS;
  wire sel_msk = paddr_in == rtc_timer_pkg::OFS_IRQ_MASK;
  wire sel_flg = paddr_in == rtc_timer_pkg::OFS_IRQ_FLAGS;
  wire sel_sfr = paddr_in == rtc_timer_pkg::OFS_SPECIAL_FUNC;
  wire mapped = sel_cnt | sel_cmp | sel_ctl | sel_sts | sel_msk | sel_flg | sel_sfr;
  // Only byte lane zero carries register data, so its strobe gates writes
  wire wr = access & pwrite_in & mapped & pstrb_in[0];
  wire [7:0] wbyte = pwdata_in[7:0];
  wire [2:0] slot_wr = {wr & sel_ctl, wr & sel_cmp, wr & sel_cnt};

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready_out = access;
  assign pslverr_out = access & ~mapped;
  assign prdata_out = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator pin synchroniser and timer source tick

  // Pin is asynchronous; only the second stage feeds the edge detector
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      xtal_meta_q <= 1'b0;
      xtal_sync_q <= 1'b0;
      xtal_prev_q <= 1'b0;
    end else begin
      xtal_meta_q <= xtal_in_pin_in;
      xtal_sync_q <= xtal_meta_q;
      xtal_prev_q <= xtal_sync_q;
    end
  end

  // Edges are only trusted while the oscillator is powered
  assign osc_enable_out = async_sel_q & ~deep_sleep_in;
  assign xtal_port_release_out = async_sel_q;
  // Edge is seen two to three system clocks after the pin moves
  wire xtal_rise = xtal_sync_q & ~xtal_prev_q & osc_enable_out;
  wire src_tick = async_sel_q ? xtal_rise : 1'b1;

  // Leaving the deepest sleep wipes the timer registers
  wire deep_exit = deep_prev_q & ~deep_sleep_in;
  wire tmr_rst = sys_rst_in | deep_exit;

  //////////////////////////////////////////////////////////////////////////////
  // Clock select and prescaler

  wire [2:0] cs = ctl_q[rtc_timer_pkg::CS_LSB +: 3];
  logic [9:0] tap_mask;

  // Tap selection; select zero stops the counter
  always_comb begin
    case (cs)
      3'h1: tap_mask = rtc_timer_pkg::TAP_DIV1;
      3'h2: tap_mask = rtc_timer_pkg::TAP_DIV8;
      3'h3: tap_mask = rtc_timer_pkg::TAP_DIV32;
      3'h4: tap_mask = rtc_timer_pkg::TAP_DIV64;
      3'h5: tap_mask = rtc_timer_pkg::TAP_DIV128;
      3'h6: tap_mask = rtc_timer_pkg::TAP_DIV256;
      default: tap_mask = rtc_timer_pkg::TAP_DIV1024;
    endcase
  end

  wire tick = (cs != 3'h0) & src_tick & ((pre_q & tap_mask) == tap_mask);
  // Only a written one requests a prescaler reset; a zero does nothing
  wire prs_wr = wr & sel_sfr & wbyte[rtc_timer_pkg::BIT_PRESCALER_RESET];
  // Async reset waits for the next oscillator edge, synchronous one acts now
  wire prs_apply = async_sel_q ? (prs_pend_q & xtal_rise) : prs_wr;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pre_q <= rtc_timer_pkg::RST_PRESCALE;
      prs_pend_q <= 1'b0;
    end else begin
      if (prs_apply) begin
        pre_q <= rtc_timer_pkg::RST_PRESCALE;
      end else if (src_tick) begin
        pre_q <= pre_q + 10'h001;
      end
      if (async_sel_q & prs_wr) begin
        prs_pend_q <= 1'b1;
      end else if (prs_apply | ~async_sel_q) begin
        prs_pend_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Temporary registers and transfer into the timer

  logic [2:0] commit;
  logic [7:0] commit_val [3];

  // One holding slot per register so pending writes never interfere
  for (genvar i = 0; i < 3; i++) begin : g_slot
    // Synchronous mode commits straight from the bus
    // Async commit on the second crystal edge seen after the write
    assign commit[i] = async_sel_q ?
                       (pend_q[i] & edge_seen_q[i] & xtal_rise) :
                       slot_wr[i];
    assign commit_val[i] = async_sel_q ? temp_q[i] : wbyte;

    always_ff @(posedge clk_sys_in) begin
      if (tmr_rst) begin
        temp_q[i] <= rtc_timer_pkg::RST_REG8;
        pend_q[i] <= 1'b0;
        edge_seen_q[i] <= 1'b0;
      end else if (slot_wr[i]) begin
        temp_q[i] <= wbyte;
        pend_q[i] <= async_sel_q;
        edge_seen_q[i] <= 1'b0;
      end else if (pend_q[i] & xtal_rise) begin
        edge_seen_q[i] <= 1'b1;
        if (edge_seen_q[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter, compare and control in the timer domain

  wire cnt_commit = commit[rtc_timer_pkg::SLOT_COUNTER];
  // Compare is blind while compare or counter transfers are in flight
  wire cmp_quiet = ~pend_q[rtc_timer_pkg::SLOT_COMPARE] & ~pend_q[rtc_timer_pkg::SLOT_COUNTER];
  wire match = tick & (cnt_q == cmp_q) & cmp_quiet & ~block_q;
  wire ovf = tick & (cnt_q == rtc_timer_pkg::COUNT_MAX) & ~cnt_commit;
  wire [1:0] com = ctl_q[rtc_timer_pkg::COM_LSB +: 2];

  always_ff @(posedge clk_sys_in) begin
    if (tmr_rst) begin
      cnt_q <= rtc_timer_pkg::RST_REG8;
      cmp_q <= rtc_timer_pkg::RST_REG8;
      ctl_q <= rtc_timer_pkg::RST_REG8;
      block_q <= 1'b0;
    end else begin
      if (cnt_commit) begin
        cnt_q <= commit_val[rtc_timer_pkg::SLOT_COUNTER];
      end else if (tick) begin
        cnt_q <= cnt_q + 8'h01;
      end
      if (commit[rtc_timer_pkg::SLOT_COMPARE]) begin
        cmp_q <= commit_val[rtc_timer_pkg::SLOT_COMPARE];
      end
      if (commit[rtc_timer_pkg::SLOT_CONTROL]) begin
        ctl_q <= commit_val[rtc_timer_pkg::SLOT_CONTROL];
      end
      // A counter write removes the match on the following timer clock
      if (cnt_commit) begin
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
      end
    end
  end

  // Pin moves with the timer tick, no extra resynchronisation stage
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      oc_q <= 1'b0;
    end else if (match) begin
      case (com)
        rtc_timer_pkg::COM_TOGGLE: oc_q <= ~oc_q;
        rtc_timer_pkg::COM_CLEAR: oc_q <= 1'b0;
        rtc_timer_pkg::COM_SET: oc_q <= 1'b1;
        default: oc_q <= oc_q;
      endcase
    end
  end
  assign compare_pin_out = oc_q;

  // Value the counter holds after this edge, so the copy never lags a tick
  wire [7:0] cnt_next = cnt_commit ? commit_val[rtc_timer_pkg::SLOT_COUNTER] :
                        tick ? cnt_q + 8'h01 : cnt_q;

  // Readable counter copy refreshed on every source edge, frozen in sleep
  // Right after wake-up it still shows the value from before sleep
  always_ff @(posedge clk_sys_in) begin
    if (tmr_rst) begin
      rd_cnt_q <= rtc_timer_pkg::RST_REG8;
    end else if (src_tick & ~light_sleep_in) begin
      rd_cnt_q <= cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt flags

  // Async events cross a three-stage processor pipe after the timer tick
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cm_pipe_q <= 3'h0;
      ov_pipe_q <= 3'h0;
    end else begin
      cm_pipe_q <= {cm_pipe_q[1:0], match & async_sel_q};
      ov_pipe_q <= {ov_pipe_q[1:0], ovf & async_sel_q};
    end
  end

  // Sync mode needs no pipe; the event is already in this domain
  wire cf_set = async_sel_q ? cm_pipe_q[rtc_timer_pkg::FLAG_SYNC_CYCLES - 1] : match;
  wire of_set = async_sel_q ? ov_pipe_q[rtc_timer_pkg::FLAG_SYNC_CYCLES - 1] : ovf;
  wire flg_wr = wr & sel_flg;
  wire cf_clr = compare_vector_ack_in | (flg_wr & wbyte[rtc_timer_pkg::BIT_COMPARE_IRQ]);
  wire of_clr = overflow_vector_ack_in | (flg_wr & wbyte[rtc_timer_pkg::BIT_OVERFLOW_IRQ]);

  // A set in the same cycle as a clear wins
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cf_q <= 1'b0;
      of_q <= 1'b0;
      mask_q <= rtc_timer_pkg::RST_REG8;
    end else begin
      cf_q <= cf_set | (cf_q & ~cf_clr);
      of_q <= of_set | (of_q & ~of_clr);
      if (wr & sel_msk) begin
        mask_q <= wbyte;
      end
    end
  end

  wire cie = mask_q[rtc_timer_pkg::BIT_COMPARE_IRQ];
  wire oie = mask_q[rtc_timer_pkg::BIT_OVERFLOW_IRQ];
  assign compare_irq_out = cf_q & cie & global_irq_enable_in;
  assign overflow_irq_out = of_q & oie & global_irq_enable_in;

  //////////////////////////////////////////////////////////////////////////////
  // Sleep, wake-up and stall

  wire irq_cond = (cf_q & cie) | (of_q & oie);

  // Wake fires on the next counter tick, so the counter always moves first
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wake_pend_q <= 1'b0;
      armed_q <= 1'b1;
      wake_q <= 1'b0;
      stall_q <= 3'h0;
      deep_prev_q <= 1'b0;
    end else begin
      deep_prev_q <= deep_sleep_in;
      wake_q <= wake_pend_q & tick;
      if (wake_pend_q & tick) begin
        wake_pend_q <= 1'b0;
      end else if (light_sleep_in & irq_cond & armed_q) begin
        wake_pend_q <= 1'b1;
      end
      // Disarm as the wake fires, else a sleep still asserted relaunches it
      // Interrupt logic rearms only after one full timer cycle
      if (wake_pend_q & tick) begin
        armed_q <= 1'b0;
      end else if (src_tick) begin
        armed_q <= 1'b1;
      end
      if (wake_q) begin
        stall_q <= rtc_timer_pkg::WAKE_STALL_CYCLES;
      end else if (stall_q != 3'h0) begin
        stall_q <= stall_q - 3'h1;
      end
    end
  end
  assign wake_out = wake_q;
  assign cpu_stall_out = stall_q != 3'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux, captured in the setup phase

  wire [7:0] sts_rd = {4'h0, async_sel_q, pend_q[rtc_timer_pkg::SLOT_COUNTER],
                       pend_q[rtc_timer_pkg::SLOT_COMPARE], pend_q[rtc_timer_pkg::SLOT_CONTROL]};
  wire [7:0] flg_rd = {cf_q, of_q, 6'h00};
  wire [7:0] sfr_rd = {6'h00, prs_pend_q, 1'b0};
  wire [7:0] cnt_rd = async_sel_q ? rd_cnt_q : cnt_q;
  // Compare and control read their temporaries
  wire [7:0] rd_byte = sel_cnt ? cnt_rd :
                       sel_cmp ? temp_q[rtc_timer_pkg::SLOT_COMPARE] :
                       sel_ctl ? temp_q[rtc_timer_pkg::SLOT_CONTROL] :
                       sel_sts ? sts_rd :
                       sel_msk ? mask_q :
                       sel_flg ? flg_rd :
                       sel_sfr ? sfr_rd : 8'h00;

  // Status writes only touch the clock select; busy bits ignore writes
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      async_sel_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      // A select change may corrupt the timer registers; software rewrites them
      if (wr & sel_sts) begin
        async_sel_q <= wbyte[rtc_timer_pkg::BIT_ASYNC_SELECT];
      end
      if (setup & ~pwrite_in) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule : async_timer_sync_and_prescaler

// ---- src/rtc_timer_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Async compare write sets compare busy; cleared once transferred.
// - Async control write sets control busy; cleared once transferred.
// - Counter reads give the timer value; compare and control read temporaries.
// - Writes land in a temporary, latched after two rising oscillator edges.
// - Each of the three registers owns its temporary; no interference.
// - Compare match is suppressed while a compare or counter write is pending.
// - Interrupt logic needs one timer cycle after wake-up before sleeping again.
// - Oscillator runs except in deepest sleeps; timer registers lost after them. Here osc_enable_out is also low while async select is clear.
// - Wake starts on next timer tick; counter advances; processor stalls four cycles.
// - Counter reads pass a copy refreshed on each oscillator edge; frozen asleep.
// - Async flag sync takes three processor cycles plus one timer cycle.
// - Compare pin changes on the timer clock without resynchronisation.
// - Mask bits 7 and 6 enable compare and overflow interrupts with global bit.
// - Compare flag bit 7 sets on match, clears by vector or written one.
// - Overflow flag bit 6 sets on overflow, clears by vector or written one.
// - Source defaults to the I/O clock; async select takes the crystal pins.
// - Prescaler gives 1, 8, 32, 64, 128, 256, 1024 and stop.
// - Writing prescaler reset restarts the prescaler phase.
// - Prescaler reset self-clears; in async mode reads one until applied.
// - Status bit 2 is counter busy, set on async write, cleared on update.
// - Status bit 3 selects clock: zero I/O clock, one crystal.
//////////////////////////////////////////////////////////////////////////////
package rtc_timer_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Register byte offsets
  localparam logic [7:0] OFS_COUNTER = 8'h00;
  localparam logic [7:0] OFS_COMPARE = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_ASYNC_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h14;
  localparam logic [7:0] OFS_SPECIAL_FUNC = 8'h18;

  // Async status fields
  localparam int BIT_CONTROL_BUSY = 0;
  localparam int BIT_COMPARE_BUSY = 1;
  localparam int BIT_COUNTER_BUSY = 2;
  localparam int BIT_ASYNC_SELECT = 3;

  // Mask and flag fields
  localparam int BIT_COMPARE_IRQ = 7;
  localparam int BIT_OVERFLOW_IRQ = 6;

  // Special function field
  localparam int BIT_PRESCALER_RESET = 1;

  // Control fields
  localparam int CS_LSB = 0;
  localparam int COM_LSB = 4;

  // Compare output actions
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [9:0] RST_PRESCALE = 10'h000;

  // Prescaler tap masks, indexed by clock select
  localparam logic [9:0] TAP_DIV1 = 10'h000;
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV32 = 10'h01F;
  localparam logic [9:0] TAP_DIV64 = 10'h03F;
  localparam logic [9:0] TAP_DIV128 = 10'h07F;
  localparam logic [9:0] TAP_DIV256 = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

  // Cycle counts
  localparam int XFER_EDGES = 2;
  localparam int FLAG_SYNC_CYCLES = 3;
  localparam logic [2:0] WAKE_STALL_CYCLES = 3'h4;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // Register slot index of the three transferred registers
  localparam int SLOT_COUNTER = 0;
  localparam int SLOT_COMPARE = 1;
  localparam int SLOT_CONTROL = 2;

endpackage : rtc_timer_pkg

// ---- testbench/xtal_osc_model.sv ----
`timescale 1ns/100ps
module xtal_osc_model #(
  parameter int HALF_NS = 100
) (
  // Oscillator control
  input wire logic osc_enable_in,
  // Crystal clock level
  output logic xtal_pin_out
);
  //////////////////////////////////////////////////////////////////////
  // Free-running watch crystal, far slower than the system clock
  // A stopped crystal rests low, so no stale edge is seen on restart
  initial xtal_pin_out = 1'b0;
  always begin
    #(HALF_NS);
    xtal_pin_out = osc_enable_in ? ~xtal_pin_out : 1'b0;
  end
endmodule : xtal_osc_model

// ---- testbench/async_timer_sync_and_prescaler_asserts.sv ----
`timescale 1ns/100ps
module async_timer_sync_and_prescaler_asserts (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register bus
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  // Clocking and processor side
  input wire logic xtal_port_release_out,
  input wire logic osc_enable_out,
  input wire logic global_irq_enable_in,
  input wire logic deep_sleep_in,
  input wire logic compare_irq_out,
  input wire logic overflow_irq_out,
  input wire logic wake_out,
  input wire logic cpu_stall_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  //////////////////////////////////////////////////////////////////////
  // Access-phase decodes
  wire logic wr_acc = psel_in && penable_in && pwrite_in && pstrb_in[0];
  wire logic rd_acc = psel_in && penable_in && !pwrite_in;
  //////////////////////////////////////////////////////////////////////
  // Interrupt gating
  property p_cmp_global; compare_irq_out |-> global_irq_enable_in; endproperty
  a_cmp_global: assert property (p_cmp_global) else $error("compare irq without global enable");
  property p_ovf_global; overflow_irq_out |-> global_irq_enable_in; endproperty
  a_ovf_global: assert property (p_ovf_global) else $error("overflow irq without global enable");
  property p_mask_cmp;
    wr_acc && paddr_in == rtc_timer_pkg::OFS_IRQ_MASK && !pwdata_in[7] |=> !compare_irq_out;
  endproperty
  a_mask_cmp: assert property (p_mask_cmp) else $error("compare irq survives mask clear");
  // Clock source and sleep
  property p_osc; osc_enable_out |-> xtal_port_release_out && !deep_sleep_in; endproperty
  a_osc: assert property (p_osc) else $error("oscillator runs outside async mode or in deep sleep");
  property p_select;
    wr_acc && paddr_in == rtc_timer_pkg::OFS_ASYNC_STATUS |=> xtal_port_release_out == $past(pwdata_in[3]);
  endproperty
  a_select: assert property (p_select) else $error("port release does not follow select bit");
  // Wake-up stall is exactly four cycles
  property p_wake_stall; wake_out |=> cpu_stall_out [*4] ##1 !cpu_stall_out; endproperty
  a_wake_stall: assert property (p_wake_stall) else $error("stall after wake not four cycles");
  property p_stall_cause; $rose(cpu_stall_out) |-> $past(wake_out); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without wake pulse");
  // Sync mode never shows busy or a pending prescaler reset
  property p_sync_busy;
    rd_acc && paddr_in == rtc_timer_pkg::OFS_ASYNC_STATUS && !xtal_port_release_out |-> prdata_out[2:0] == 3'b000;
  endproperty
  a_sync_busy: assert property (p_sync_busy) else $error("busy flag set in sync mode");
  property p_psr_sync;
    rd_acc && paddr_in == rtc_timer_pkg::OFS_SPECIAL_FUNC && !xtal_port_release_out |-> !prdata_out[1];
  endproperty
  a_psr_sync: assert property (p_psr_sync) else $error("prescaler reset reads one in sync mode");
endmodule : async_timer_sync_and_prescaler_asserts

bind async_timer_sync_and_prescaler async_timer_sync_and_prescaler_asserts u_asserts (
  .clk_sys_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
  .prdata_out, .xtal_port_release_out, .osc_enable_out, .global_irq_enable_in, .deep_sleep_in,
  .compare_irq_out, .overflow_irq_out, .wake_out, .cpu_stall_out
);

// ---- testbench/async_timer_sync_and_prescaler_bench.sv ----
`timescale 1ns/100ps
module async_timer_sync_and_prescaler_bench;
  logic clk_sys_in, sys_rst_in, psel_in, penable_in, pwrite_in, e;
  logic global_irq_enable_in, compare_vector_ack_in, overflow_vector_ack_in, light_sleep_in, deep_sleep_in;
  logic [7:0] paddr_in, d;
  logic [31:0] pwdata_in;
  logic [3:0] pstrb_in;
  wire logic [31:0] prdata_out;
  wire logic pready_out, pslverr_out, xtal_in_pin_in, xtal_port_release_out, osc_enable_out;
  wire logic compare_irq_out, overflow_irq_out, wake_out, cpu_stall_out, compare_pin_out;
  wire logic [2:0] evt = {wake_out, overflow_irq_out, compare_irq_out};
  int errors, total_checks, n;
  realtime t0;
  // Count after 2048 clocks per clock select, modulo 256
  logic [7:0] exp_cnt [8] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};

  async_timer_sync_and_prescaler uut (
    .clk_sys_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
    .prdata_out, .pready_out, .pslverr_out, .xtal_in_pin_in, .xtal_port_release_out, .osc_enable_out,
    .global_irq_enable_in, .compare_vector_ack_in, .overflow_vector_ack_in, .light_sleep_in,
    .deep_sleep_in, .compare_irq_out, .overflow_irq_out, .wake_out, .cpu_stall_out, .compare_pin_out
  );
  xtal_osc_model xtal (.osc_enable_in(osc_enable_out), .xtal_pin_out(xtal_in_pin_in));

  always #(rtc_timer_pkg::CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
  //////////////////////////////////////////////////////////////////////
  // One APB transfer; an idle cycle follows so strobes never re-assert in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h00_0000, v};
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    d = prdata_out[7:0];
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask : rd

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : check

  // Counts taken across clock domains may slip a few ticks either way
  task automatic check_near(input logic [7:0] got, input logic [7:0] exp);
    logic [7:0] df;
    df = got - exp;
    check((df <= 8'h03 || df >= 8'hFD) ? exp : got, exp);
  endtask : check_near

  // Poll status until no transfer is pending; never write a busy register meanwhile
  task automatic wait_idle();
    n = 0;
    do begin
      rd(rtc_timer_pkg::OFS_ASYNC_STATUS);
      n++;
    end while (d[2:0] !== 3'b000 && n < 200);
    check(d[2:0], 3'b000);
  endtask : wait_idle

  // Sampled at the falling edge, where one-cycle pulses have settled
  task automatic await(input int which);
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (evt[which] !== 1'b1 && n < 600);
    check(evt[which], 1'b1);
    @(posedge clk_sys_in);
  endtask : await

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {clk_sys_in, psel_in, penable_in, pwrite_in, global_irq_enable_in} = 5'h00;
    {compare_vector_ack_in, overflow_vector_ack_in, light_sleep_in, deep_sleep_in} = 4'h0;
    sys_rst_in = 1'b1;
    paddr_in = 8'h00;
    pwdata_in = 32'h0000_0000;
    pstrb_in = 4'hF;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rd(rtc_timer_pkg::OFS_IRQ_MASK);
    check(d, 8'h00);
    rd(rtc_timer_pkg::OFS_ASYNC_STATUS);
    check(d, 8'h00);
    rd(8'h40);
    check(e, 1'b1);
    wr(rtc_timer_pkg::OFS_COMPARE, 8'h55);
    rd(rtc_timer_pkg::OFS_COMPARE);
    check(d, 8'h55);
    // Every clock select, each from a freshly reset prescaler
    for (int cs = 0; cs < 8; cs++) begin
      wr(rtc_timer_pkg::OFS_CONTROL, 8'h00);
      wr(rtc_timer_pkg::OFS_COUNTER, 8'h00);
      wr(rtc_timer_pkg::OFS_SPECIAL_FUNC, 8'h02);
      wr(rtc_timer_pkg::OFS_CONTROL, 8'(cs));
      repeat (2048) @(posedge clk_sys_in);
      rd(rtc_timer_pkg::OFS_COUNTER);
      check_near(d, exp_cnt[cs]);
    end
    rd(rtc_timer_pkg::OFS_SPECIAL_FUNC);
    check(d, 8'h00);
    // Sync mode: compare and overflow flags, pin toggle, both clear paths
    wr(rtc_timer_pkg::OFS_CONTROL, 8'h00);
    wr(rtc_timer_pkg::OFS_IRQ_FLAGS, 8'hC0);
    wr(rtc_timer_pkg::OFS_IRQ_MASK, 8'hC0);
    global_irq_enable_in <= 1'b1;
    wr(rtc_timer_pkg::OFS_COMPARE, 8'hF8);
    wr(rtc_timer_pkg::OFS_COUNTER, 8'hF0);
    wr(rtc_timer_pkg::OFS_CONTROL, 8'h11);
    await(0);
    check(compare_pin_out, 1'b1);
    await(1);
    wr(rtc_timer_pkg::OFS_CONTROL, 8'h00);
    global_irq_enable_in <= 1'b0;
    @(posedge clk_sys_in);
    check(compare_irq_out, 1'b0);
    global_irq_enable_in <= 1'b1;
    compare_vector_ack_in <= 1'b1;
    @(posedge clk_sys_in);
    compare_vector_ack_in <= 1'b0;
    rd(rtc_timer_pkg::OFS_IRQ_FLAGS);
    check(d, 8'h40);
    wr(rtc_timer_pkg::OFS_IRQ_FLAGS, 8'h40);
    rd(rtc_timer_pkg::OFS_IRQ_FLAGS);
    check(d, 8'h00);
    // Move to the crystal: interrupts off, select, rewrite all three, await busy
    wr(rtc_timer_pkg::OFS_IRQ_MASK, 8'h00);
    wr(rtc_timer_pkg::OFS_ASYNC_STATUS, 8'h08);
    check(xtal_port_release_out, 1'b1);
    wr(rtc_timer_pkg::OFS_COMPARE, 8'h33);
    t0 = $realtime;
    rd(rtc_timer_pkg::OFS_ASYNC_STATUS);
    check(d, 8'h0A);
    rd(rtc_timer_pkg::OFS_COMPARE);
    check(d, 8'h33);
    wait_idle();
    check($realtime - t0 >= 180.0, 1'b1);
    wr(rtc_timer_pkg::OFS_CONTROL, 8'h01);
    wr(rtc_timer_pkg::OFS_COUNTER, 8'h10);
    rd(rtc_timer_pkg::OFS_ASYNC_STATUS);
    check(d, 8'h0D);
    wait_idle();
    wr(rtc_timer_pkg::OFS_ASYNC_STATUS, 8'h0F);
    rd(rtc_timer_pkg::OFS_ASYNC_STATUS);
    check(d, 8'h08);
    rd(rtc_timer_pkg::OFS_COMPARE);
    check(d, 8'h33);
    rd(rtc_timer_pkg::OFS_CONTROL);
    check(d, 8'h01);
    repeat (1000) @(posedge clk_sys_in);
    rd(rtc_timer_pkg::OFS_COUNTER);
    check_near(d, 8'h43);
    // Align away from a crystal edge so the pending reset is still visible
    @(negedge xtal_in_pin_in);
    @(posedge clk_sys_in);
    wr(rtc_timer_pkg::OFS_SPECIAL_FUNC, 8'h02);
    rd(rtc_timer_pkg::OFS_SPECIAL_FUNC);
    check(d[1], 1'b1);
    repeat (60) @(posedge clk_sys_in);
    rd(rtc_timer_pkg::OFS_SPECIAL_FUNC);
    check(d[1], 1'b0);
    // Overflow wakes the processor from light sleep
    wr(rtc_timer_pkg::OFS_IRQ_FLAGS, 8'hC0);
    wr(rtc_timer_pkg::OFS_COUNTER, 8'hFC);
    wait_idle();
    wr(rtc_timer_pkg::OFS_IRQ_MASK, 8'h40);
    light_sleep_in <= 1'b1;
    await(2);
    light_sleep_in <= 1'b0;
    wr(rtc_timer_pkg::OFS_CONTROL, 8'h01);
    wait_idle();
    rd(rtc_timer_pkg::OFS_IRQ_FLAGS);
    check(d, 8'h40);
    // Deep sleep stops the crystal and loses the timer registers
    deep_sleep_in <= 1'b1;
    @(posedge clk_sys_in);
    check(osc_enable_out, 1'b0);
    deep_sleep_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rd(rtc_timer_pkg::OFS_COMPARE);
    check(d, 8'h00);
    complete_run();
  end

  // Watchdog: the sequence needs about 18k cycles, so 100k means a hang
  initial begin
    #(100_000 * rtc_timer_pkg::CLK_PERIOD_NS);
    errors++;
    complete_run();
  end
endmodule : async_timer_sync_and_prescaler_bench
